// >>> core/rscr_pkg.sv
// Operation
// - Filter register bit 2 enables the channel 2 noise filter, bit 0 the channel 1 filter, other bits read zero.
// - After reset the filter register holds 05h, both filters on.
// - Model register bit 2 picks channel 2 model, bit 0 channel 1, 1 means processor diode, other bits read zero.
// - After reset the channel 2 model bit is 0, discrete transistor model.
// - After reset the channel 1 model bit is 1 and all other model bits are 0.
// - Mode register bits 6-4 give channel 2 mode: 000 off, 001 and 111 on.
// - Mode register bits 2-0 give channel 1 mode with the same codes.
// - An enabled mode sets that channel's active flag, fully active within one conversion.
// - Filter on gives 1/32 degree result steps, filter off 1/8 degree with low bits zero.
package rscr_pkg;
	localparam logic [7:0] ADDR_FILTER = 8'h06;
	localparam logic [7:0] ADDR_MODE = 8'h07;
	localparam logic [7:0] ADDR_MODEL = 8'h30;
	localparam logic [7:0] RST_FILTER = 8'h05;
	localparam logic [7:0] RST_MODE = 8'h01;
	localparam logic [7:0] RST_MODEL = 8'h01;
	localparam logic [7:0] MASK_FILTER = 8'h05;
	localparam logic [7:0] MASK_MODEL = 8'h05;
	localparam logic [7:0] MASK_MODE = 8'h77;
	localparam int CH2_BIT = 2;
	localparam int CH1_BIT = 0;
	localparam int CH2_MODE_LSB = 4;
	localparam int CH1_MODE_LSB = 0;
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_ON_A = 3'h1;
	localparam logic [2:0] MODE_ON_B = 3'h7;
	localparam logic [2:0] FINE_LOW_MASK = 3'h0;
	localparam logic [4:0] COARSE_LOW_MASK = 5'h00;

	typedef struct packed {
		logic filter_on;
		logic model_pick;
		logic mode_on;
	} rscr_chan_cfg_t;
endpackage

// >>> core/rscr_chan_latch.sv
`timescale 1ns/1ps
`default_nettype none
module rscr_chan_latch (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// settings and conversion start
	input wire rscr_pkg::rscr_chan_cfg_t cfg_i,
	input wire logic conv_start_i,
	// live settings
	output var rscr_pkg::rscr_chan_cfg_t cfg_o
);
	rscr_pkg::rscr_chan_cfg_t cfg_r;

	// only sampled at conversion start; mid-conversion writes wait
	always_ff @(posedge clock_i) begin
		if (reset_i)
			cfg_r <= '0;
		else if (conv_start_i)
			cfg_r <= cfg_i;
	end

	assign cfg_o = cfg_r;
endmodule // rscr_chan_latch
`default_nettype wire

// >>> core/rscr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rscr_regs (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// register port from the serial interface
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_hit_o,
	// conversion engine handshake
	input wire logic ch1_conv_start_i,
	input wire logic ch2_conv_start_i,
	input wire logic ch1_conv_done_i,
	input wire logic ch2_conv_done_i,
	input wire logic [12:0] ch1_raw_i,
	input wire logic [12:0] ch2_raw_i,
	// settings applied to conversion
	output logic ch1_filter_on_o,
	output logic ch2_filter_on_o,
	output logic ch1_model_pick_o,
	output logic ch2_model_pick_o,
	output logic [1:0] ch_measure_mode_active_flag_o,
	output logic [12:0] ch1_result_o,
	output logic [12:0] ch2_result_o
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] filter_r;
	logic [7:0] model_r;
	logic [7:0] mode_r;
	logic [7:0] rdata_nxt;
	logic hit_nxt;
	logic [2:0] ch1_measure_mode_code;
	logic [2:0] ch2_measure_mode_code;
	logic ch1_mode_on;
	logic ch2_mode_on;
	rscr_pkg::rscr_chan_cfg_t ch1_cfg;
	rscr_pkg::rscr_chan_cfg_t ch2_cfg;
	rscr_pkg::rscr_chan_cfg_t ch1_live;
	rscr_pkg::rscr_chan_cfg_t ch2_live;
	logic wr_filter;
	logic wr_model;
	logic wr_mode;

	////////////////////////////////////////////////////////////////////////
	// package sanity; a bad constant would silently mis-map a field
	if (rscr_pkg::CH1_BIT >= rscr_pkg::CH2_BIT ||
		rscr_pkg::CH2_BIT > 7) begin : g_bad_chan_bits
		$error("channel bit positions do not fit the register");
	end
	if (rscr_pkg::CH2_MODE_LSB + 3 > 8) begin : g_bad_ch2_field
		$error("channel 2 mode field leaves the register");
	end
	if (rscr_pkg::CH1_MODE_LSB + 3 >
		rscr_pkg::CH2_MODE_LSB) begin : g_bad_mode_overlap
		$error("channel mode fields overlap");
	end
	if (rscr_pkg::MODE_ON_A == rscr_pkg::MODE_OFF ||
		rscr_pkg::MODE_ON_B == rscr_pkg::MODE_OFF) begin : g_bad_codes
		$error("an enable code equals the off code");
	end
	// filter and model share the channel bit positions
	if (rscr_pkg::MASK_FILTER != rscr_pkg::MASK_MODEL) begin : g_bad_masks
		$error("filter and model bit maps differ");
	end
	if ((rscr_pkg::RST_FILTER & ~rscr_pkg::MASK_FILTER) !=
		8'h00) begin : g_bad_filter_rst
		$error("filter reset value sets a reserved bit");
	end
	if ((rscr_pkg::RST_MODEL & ~rscr_pkg::MASK_MODEL) !=
		8'h00) begin : g_bad_model_rst
		$error("model reset value sets a reserved bit");
	end
	if ((rscr_pkg::RST_MODE & ~rscr_pkg::MASK_MODE) !=
		8'h00) begin : g_bad_mode_rst
		$error("mode reset value sets a reserved bit");
	end

	////////////////////////////////////////////////////////////////////////
	// write decode; unmapped addresses match nothing and are ignored
	assign wr_filter = reg_wr_i && (reg_addr_i == rscr_pkg::ADDR_FILTER);
	assign wr_model = reg_wr_i && (reg_addr_i == rscr_pkg::ADDR_MODEL);
	assign wr_mode = reg_wr_i && (reg_addr_i == rscr_pkg::ADDR_MODE);

	////////////////////////////////////////////////////////////////////////
	// register writes; reserved bits never stored so they read zero
	always_ff @(posedge clock_i) begin
		if (reset_i)
			filter_r <= rscr_pkg::RST_FILTER;
		else if (wr_filter)
			filter_r <= reg_wdata_i & rscr_pkg::MASK_FILTER;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i)
			model_r <= rscr_pkg::RST_MODEL;
		else if (wr_model)
			model_r <= reg_wdata_i & rscr_pkg::MASK_MODEL;
	end

	// bits 7 and 3 masked even if software forgets them
	always_ff @(posedge clock_i) begin
		if (reset_i)
			mode_r <= rscr_pkg::RST_MODE;
		else if (wr_mode)
			mode_r <= reg_wdata_i & rscr_pkg::MASK_MODE;
	end

	////////////////////////////////////////////////////////////////////////
	// mode decode; undefined codes treated as off
	assign ch2_measure_mode_code = mode_r[rscr_pkg::CH2_MODE_LSB +: 3];
	assign ch1_measure_mode_code = mode_r[rscr_pkg::CH1_MODE_LSB +: 3];
	// undefined codes are forbidden to software and read here as off
	function automatic logic mode_is_on(input logic [2:0] code);
		logic on;
		on = 1'b0;
		unique case (code)
			rscr_pkg::MODE_OFF: on = 1'b0;
			rscr_pkg::MODE_ON_A: on = 1'b1;
			rscr_pkg::MODE_ON_B: on = 1'b1;
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	assign ch2_mode_on = mode_is_on(ch2_measure_mode_code);
	assign ch1_mode_on = mode_is_on(ch1_measure_mode_code);

	assign ch1_cfg = '{filter_on: filter_r[rscr_pkg::CH1_BIT],
		model_pick: model_r[rscr_pkg::CH1_BIT], mode_on: ch1_mode_on};
	assign ch2_cfg = '{filter_on: filter_r[rscr_pkg::CH2_BIT],
		model_pick: model_r[rscr_pkg::CH2_BIT], mode_on: ch2_mode_on};

	rscr_chan_latch u_ch1 (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.cfg_i(ch1_cfg),
		.conv_start_i(ch1_conv_start_i),
		.cfg_o(ch1_live)
	);

	rscr_chan_latch u_ch2 (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.cfg_i(ch2_cfg),
		.conv_start_i(ch2_conv_start_i),
		.cfg_o(ch2_live)
	);

	////////////////////////////////////////////////////////////////////////
	// settings out, registered; zero until the first conversion start
	always_ff @(posedge clock_i) begin
		if (reset_i)
			ch1_filter_on_o <= 1'b0;
		else
			ch1_filter_on_o <= ch1_live.filter_on;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i)
			ch2_filter_on_o <= 1'b0;
		else
			ch2_filter_on_o <= ch2_live.filter_on;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i)
			ch1_model_pick_o <= 1'b0;
		else
			ch1_model_pick_o <= ch1_live.model_pick;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i)
			ch2_model_pick_o <= 1'b0;
		else
			ch2_model_pick_o <= ch2_live.model_pick;
	end

	// flag follows the latched mode, so it rises with the next conversion
	always_ff @(posedge clock_i) begin
		if (reset_i)
			ch_measure_mode_active_flag_o <= 2'h0;
		else
			ch_measure_mode_active_flag_o <=
				{ch2_live.mode_on, ch1_live.mode_on};
	end

	// resolution: zero unused low bits per filter setting
	always_ff @(posedge clock_i) begin
		if (reset_i)
			ch1_result_o <= 13'h0000;
		else if (ch1_conv_done_i)
			ch1_result_o <= ch1_live.filter_on ?
				ch1_raw_i : {ch1_raw_i[12:2], 2'h0};
	end

	always_ff @(posedge clock_i) begin
		if (reset_i)
			ch2_result_o <= 13'h0000;
		else if (ch2_conv_done_i)
			ch2_result_o <= ch2_live.filter_on ?
				ch2_raw_i : {ch2_raw_i[12:2], 2'h0};
	end

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		rdata_nxt = 8'h00;
		hit_nxt = 1'b1;
		unique case (reg_addr_i)
			rscr_pkg::ADDR_FILTER: rdata_nxt = filter_r;
			rscr_pkg::ADDR_MODEL: rdata_nxt = model_r;
			rscr_pkg::ADDR_MODE: rdata_nxt = mode_r;
			default: hit_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
			reg_hit_o <= 1'b0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_nxt;
			reg_hit_o <= hit_nxt;
		end
	end
endmodule // rscr_regs
`default_nettype wire

// >>> sim/rscr_host.sv
`timescale 1ns/1ps
`default_nettype none
module rscr_host (
	// clock
	input wire logic clock_i,
	// register strobes
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	output logic rd_o
);
	initial begin
		{addr_o, wr_o, wdata_o, rd_o} = '0;
	end
	// one byte per strobe; data scrambled outside a write
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		addr_o = a;
		wdata_o = w ? d : ~wdata_o;
		wr_o = w;
		rd_o = !w;
		@(negedge clock_i);
		{wr_o, rd_o} = 2'h0;
		wdata_o = ~wdata_o;
	endtask
endmodule // rscr_host
`default_nettype wire

// >>> sim/rscr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rscr_regs_asserts (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic ch1_conv_start_i,
	input wire logic ch1_conv_done_i,
	input wire logic [12:0] ch1_raw_i,
	input wire logic ch1_filter_on_o,
	input wire logic [1:0] ch_measure_mode_active_flag_o,
	input wire logic [12:0] ch1_result_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	property p_flt;
		reg_rd_i && reg_addr_i == 8'h06 |=> !(reg_rdata_o & 8'hFA); endproperty
	a_flt: assert property (p_flt) else $error("filter rsv");
	property p_mdl;
		reg_rd_i && reg_addr_i == 8'h30 |=> !(reg_rdata_o & 8'hFA); endproperty
	a_mdl: assert property (p_mdl) else $error("model rsv");
	property p_mod;
		reg_rd_i && reg_addr_i == 8'h07 |=> !(reg_rdata_o & 8'h88); endproperty
	a_mod: assert property (p_mod) else $error("mode rsv");
	property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
	property p_flag; $changed(ch_measure_mode_active_flag_o[0]) |->
		$past(ch1_conv_start_i, 2); endproperty
	a_flag: assert property (p_flag) else $error("flag timing");
	property p_filt;
		$changed(ch1_filter_on_o) |-> $past(ch1_conv_start_i, 2); endproperty
	a_filt: assert property (p_filt) else $error("filter mid");
	property p_res; ch1_conv_done_i && !ch1_filter_on_o |=>
		ch1_result_o[1:0] == 2'h0; endproperty
	a_res: assert property (p_res) else $error("coarse low");
	property p_raw; ch1_conv_done_i |=>
		ch1_result_o[12:2] == $past(ch1_raw_i[12:2]); endproperty
	a_raw: assert property (p_raw) else $error("result");
endmodule // rscr_regs_asserts
bind rscr_regs rscr_regs_asserts rscr_regs_asserts_inst (.*);
`default_nettype wire

// >>> sim/rscr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rscr_regs_tb;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic wr, rd, hit, s, d, f1, f2, m1, m2;
	logic seen = 1'b0;
	logic p = 1'b0;
	logic [7:0] a, wd, rdat;
	logic [12:0] r1, r2, o1, o2;
	logic [1:0] fl;
	logic [8:0] q[$];
	logic [15:0] seed = 16'hED98;
	logic [15:0] w;
	logic [2:0] c;
	logic [2:0] codes [3] = '{3'h0, 3'h1, 3'h7};
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;
	initial forever #12.5 clock_i = ~clock_i;
	rscr_host rscr_host_inst (.clock_i, .addr_o(a), .wr_o(wr), .wdata_o(wd),
		.rd_o(rd));
	rscr_regs rscr_regs_inst (.clock_i, .reset_i, .reg_addr_i(a), .reg_wr_i(wr),
		.reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdat), .reg_hit_o(hit),
		.ch1_conv_start_i(s), .ch2_conv_start_i(s), .ch1_conv_done_i(d),
		.ch2_conv_done_i(d), .ch1_raw_i(r1), .ch2_raw_i(r2),
		.ch1_filter_on_o(f1), .ch2_filter_on_o(f2), .ch1_model_pick_o(m1),
		.ch2_model_pick_o(m2), .ch_measure_mode_active_flag_o(fl),
		.ch1_result_o(o1), .ch2_result_o(o2));
	function automatic logic [15:0] rnd();
		seed ^= seed << 7;
		seed ^= seed >> 9;
		seed ^= seed << 8;
		return seed;
	endfunction
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %h vs %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic rdx(input logic [7:0] ad, input logic [7:0] e, input logic h);
		q.push_back({h, e});
		rscr_host_inst.xfer(1'b0, ad, 8'h00);
	endtask
	// both channels share strobes; results land long after start
	task automatic conv();
		@(negedge clock_i) s = 1'b1;
		@(negedge clock_i) s = 1'b0;
		repeat (3) @(negedge clock_i);
		r1 = 13'(rnd());
		r2 = 13'(rnd());
		d = 1'b1;
		@(negedge clock_i) d = 1'b0;
	endtask
	always @(posedge clock_i) begin
		seen <= rd;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	always @(negedge clock_i) if (seen && q.size() > 0)
		chk({4'h0, hit, rdat}, {4'h0, q.pop_front()});
	initial begin
		{s, d, r1, r2} = '0;
		repeat (16) @(negedge clock_i);
		reset_i = 1'b0;
		rdx(8'h06, rscr_pkg::RST_FILTER, 1'b1);
		rdx(8'h30, rscr_pkg::RST_MODEL, 1'b1);
		rdx(8'h07, rscr_pkg::RST_MODE, 1'b1);
		rdx(8'h55, 8'h00, 1'b0);
		repeat (6) begin
			w = rnd();
			rscr_host_inst.xfer(1'b1, 8'h06, w[7:0]);
			rscr_host_inst.xfer(1'b1, 8'h55, w[15:8]);
			rdx(8'h06, w[7:0] & rscr_pkg::MASK_FILTER, 1'b1);
			rscr_host_inst.xfer(1'b1, 8'h30, w[15:8]);
			rdx(8'h30, w[15:8] & rscr_pkg::MASK_MODEL, 1'b1);
		end
		foreach (codes[i]) begin
			c = codes[i];
			rscr_host_inst.xfer(1'b1, 8'h07, {1'b0, c, 1'b0, c});
			rscr_host_inst.xfer(1'b1, 8'h30, {5'h00, c[0], 1'b0, c[0]});
			rscr_host_inst.xfer(1'b1, 8'h06, {5'h00, c[0], 1'b0, c[0]});
			rdx(8'h07, {1'b0, c, 1'b0, c}, 1'b1);
			chk({7'h00, f1, f2, m1, m2, fl}, {7'h00, {6{p}}});
			conv();
			@(negedge clock_i);
			chk({7'h00, f1, f2, m1, m2, fl}, {7'h00, {6{c[0]}}});
			chk(o1, r1 & {11'h7FF, {2{c[0]}}});
			chk(o2, r2 & {11'h7FF, {2{c[0]}}});
			p = c[0];
		end
		repeat (3) @(negedge clock_i);
		print_verdict();
	end
endmodule // rscr_regs_tb
`default_nettype wire
